// file: hw/gptcp_timer.sv
// Notes on behaviour
// - no prescaler in edge or pwm modes
// - each selected edge decrements; match sets flag
// - on match reload, clear enable, ignore edges
// - capture mode free-runs from load, reset ffff
// - edge copies count to value reg, flags
// - edge time keeps counting, reloads at zero
// - captured value holds until next edge
// - pwm counts down, reloads, no status
// - pwm set at load, cleared at match
// - level bit inverts pwm output
// - config 0 selects 32-bit one-shot/periodic
// - writing clear bit clears timeout flag
// - one-shot stops, periodic keeps counting
// - rtc match sets flag, keeps counting
// - rtc divides input to 1 Hz
// - one-shot reloads and clears enable in the same cycle
// - load write taken next clock cycle
// - 32-bit load/value split across halves
`timescale 1ns/100ps
`default_nettype none
module gptcp_timer
  import gptcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [6:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic ccp_in,
  output logic pwm_out
);
  logic [2:0] cfg_reg;
  logic [3:0] mode_reg;
  logic [6:0] ctl_reg, ctl_next;
  gptcp_sts_t mask_reg, ris_reg, ris_next, sts_set;
  logic [15:0] load_a_reg, load_b_reg, match_a_reg;
  logic [7:0] pre_a_reg, pre_cnt_reg, pre_cnt_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [15:0] cap_reg, cap_next;
  logic [14:0] div_reg, div_next;
  logic pwm_raw_reg, pwm_raw_next;
  logic sync1_reg, sync2_reg, prev_reg;
  logic wait_reg, en_clr;
  logic [31:0] rdata_reg;

  // bus handshake: one wait cycle, transfer completes on the next edge
  wire req = read | write;
  wire wr_go = write & ~wait_reg;
  wire rd_take = read & wait_reg;
  wire wr_cfg = wr_go && address == OFS_CFG;
  wire wr_mode = wr_go && address == OFS_MODE;
  wire wr_ctl = wr_go && address == OFS_CTL;
  wire wr_mask = wr_go && address == OFS_MASK;
  wire wr_clr = wr_go && address == OFS_CLR;
  wire wr_load_a = wr_go && address == OFS_LOAD_A;
  wire wr_load_b = wr_go && address == OFS_LOAD_B;
  wire wr_match = wr_go && address == OFS_MATCH_A;
  wire wr_pre = wr_go && address == OFS_PRE_A;

  wire enabled = ctl_reg[CTL_EN_BIT];
  wire [1:0] evt_sel = ctl_reg[CTL_EVT_LO +: 2];
  wire pwm_inv = ctl_reg[CTL_PWML_BIT];
  wire is_split = cfg_reg == CFG_16;

  // 32-bit or split decode of the operating mode
  // capture bit clear selects edge count, pwm decode
  gptcp_mode_t mode;
  always_comb begin
    mode = MD_IDLE;
    if (cfg_reg == CFG_RTC) begin
      mode = MD_RTC;
    end else if (cfg_reg == CFG_32 || is_split) begin
      if (is_split && mode_reg[1:0] == MR_CAP) begin
        mode = mode_reg[MR_CMR_BIT] ? MD_ETIM : MD_ECNT;
      end else if (is_split && mode_reg[MR_AMS_BIT] && !mode_reg[MR_CMR_BIT]
                   && mode_reg[1:0] == MR_PER) begin
        mode = MD_PWM;
      end else if (mode_reg[1:0] == MR_ONE) begin
        mode = MD_ONE;
      end else if (mode_reg[1:0] == MR_PER) begin
        mode = MD_PER;
      end
    end
  end

  // pin synchroniser, edges only seen past the second stage
  wire rise = sync2_reg & ~prev_reg;
  wire fall = ~sync2_reg & prev_reg;
  wire edge_hit = (evt_sel == EVT_RISE && rise) || (evt_sel == EVT_FALL && fall) ||
                  (evt_sel == EVT_BOTH && (rise | fall));

  // 32-bit view joins the upper half with the lower half
  wire [31:0] load_w = is_split ? {16'h0000, load_a_reg} : {load_b_reg, load_a_reg};
  wire [15:0] cnt16 = cnt_reg[15:0];
  wire [15:0] cnt16_dec = cnt16 - 16'h0001;
  wire cnt_zero = is_split ? (cnt16 == 16'h0000) : (cnt_reg == 32'h00000000);
  // prescaler only gates split one-shot and periodic counting
  wire pre_use = is_split && (mode == MD_ONE || mode == MD_PER);
  wire tick = !pre_use || pre_cnt_reg == 8'h00;
  wire [31:0] cnt_dec = is_split ? {16'h0000, cnt16_dec} : cnt_reg - 32'h00000001;

  always_comb begin
    cnt_next = cnt_reg;
    pre_cnt_next = pre_cnt_reg;
    cap_next = cap_reg;
    div_next = div_reg;
    pwm_raw_next = pwm_raw_reg;
    sts_set = '0;
    en_clr = 1'b0;
    if (enabled) begin
      unique case (mode)
        MD_ONE, MD_PER: begin
          if (!tick) begin
            pre_cnt_next = pre_cnt_reg - 8'h01;
          end else begin
            pre_cnt_next = pre_a_reg;
            // one-shot stops, reload and drop enable in the same cycle
            if (cnt_zero) begin
              cnt_next = load_w;
              sts_set.tout = 1'b1;
              en_clr = mode == MD_ONE;
            end else begin
              cnt_next = cnt_dec;
            end
          end
        end
        MD_RTC: begin
          // one count per 32768 input rising edges
          if (rise) begin
            div_next = div_reg + 15'h0001;
            if (div_reg == RTC_DIV_LAST) begin
              // match rolls over and raises the clock flag
              if (cnt_reg == {load_b_reg, match_a_reg}) begin
                cnt_next = '0;
                sts_set.rtc = 1'b1;
              end else begin
                cnt_next = cnt_reg + 32'h00000001;
              end
            end
          end
        end
        MD_ECNT: begin
          // selected edge decrements, match reloads and stops
          if (edge_hit) begin
            if (cnt16_dec == match_a_reg) begin
              cnt_next = load_w;
              sts_set.cap_match = 1'b1;
              en_clr = 1'b1;
            end else begin
              cnt_next = {16'h0000, cnt16_dec};
            end
          end
        end
        MD_ETIM, MD_PWM: begin
          // free-run with reload at zero, same for pwm
          cnt_next = cnt_zero ? load_w : {16'h0000, cnt16_dec};
          // capture count on edge, held otherwise
          if (mode == MD_ETIM && edge_hit) begin
            cap_next = cnt16;
            sts_set.cap_evt = 1'b1;
          end
          // assert at start value, release at match
          if (mode == MD_PWM) begin
            if (cnt16 == load_a_reg) begin
              pwm_raw_next = 1'b1;
            end else if (cnt16 == match_a_reg) begin
              pwm_raw_next = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
    // a load write replaces the running count next cycle
    if (wr_load_a) begin
      cnt_next = is_split ? {16'h0000, writedata[15:0]} : writedata;
    end
    if (wr_cfg && writedata[2:0] == CFG_RTC) begin
      cnt_next = RTC_START;
      div_next = '0;
    end
  end

  // write-one clears; a same-cycle set wins
  assign ris_next = (ris_reg & ~(wr_clr ? gptcp_sts_t'(writedata[3:0]) : '0)) | sts_set;
  assign ctl_next = wr_ctl ? writedata[6:0] : (ctl_reg & ~{6'h00, en_clr});

  wire [31:0] val_a = (mode == MD_ETIM) ? {16'h0000, cap_reg} : cnt_reg;
  wire [31:0] rd_mux =
    address == OFS_CFG ? {29'h0, cfg_reg} :
    address == OFS_MODE ? {28'h0, mode_reg} :
    address == OFS_CTL ? {25'h0, ctl_reg} :
    address == OFS_MASK ? {28'h0, mask_reg} :
    address == OFS_RAW ? {28'h0, ris_reg} :
    address == OFS_MSK_STS ? {28'h0, ris_reg & mask_reg} :
    address == OFS_LOAD_A ? load_w :
    address == OFS_LOAD_B ? {16'h0000, load_b_reg} :
    address == OFS_MATCH_A ? {16'h0000, match_a_reg} :
    address == OFS_PRE_A ? {24'h0, pre_a_reg} :
    address == OFS_VAL_A ? (is_split ? {16'h0000, val_a[15:0]} : val_a) :
    address == OFS_VAL_B ? {16'h0000, cnt_reg[31:16]} : 32'h00000000;

  always_ff @(posedge clk) begin
    if (rst) begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      wait_reg <= ~(req & wait_reg);
      if (rd_take) begin
        rdata_reg <= rd_mux;
      end
      sync1_reg <= ccp_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg <= '0;
      mode_reg <= '0;
      ctl_reg <= '0;
      mask_reg <= '0;
      ris_reg <= '0;
      load_a_reg <= LOAD_RST;
      load_b_reg <= LOAD_RST;
      match_a_reg <= LOAD_RST;
      pre_a_reg <= '0;
    end else begin
      if (wr_cfg) cfg_reg <= writedata[2:0];
      if (wr_mode) mode_reg <= writedata[3:0];
      if (wr_mask) mask_reg <= gptcp_sts_t'(writedata[3:0]);
      if (wr_load_a) load_a_reg <= writedata[15:0];
      // upper word of a 32-bit load lands in the upper half
      if (wr_load_a && !is_split) load_b_reg <= writedata[31:16];
      else if (wr_load_b) load_b_reg <= writedata[15:0];
      if (wr_match) match_a_reg <= writedata[15:0];
      if (wr_match && !is_split) load_b_reg <= load_b_reg;
      if (wr_pre) pre_a_reg <= writedata[7:0];
      ctl_reg <= ctl_next;
      ris_reg <= ris_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= CNT_RST;
      pre_cnt_reg <= '0;
      cap_reg <= '0;
      div_reg <= '0;
      pwm_raw_reg <= 1'b0;
      pwm_out <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      pre_cnt_reg <= pre_cnt_next;
      cap_reg <= cap_next;
      div_reg <= div_next;
      pwm_raw_reg <= pwm_raw_next;
      // level bit inverts the driven waveform
      pwm_out <= pwm_raw_next ^ pwm_inv;
    end
  end

  assign readdata = rdata_reg;
  assign waitrequest = wait_reg;

  a_bus_wait_one: assert property (@(posedge clk) disable iff (rst) // bus
    req && waitrequest |=> !waitrequest) else $error("no answer after one wait cycle");
  a_ecnt_match_stop: assert property (@(posedge clk) disable iff (rst)
    enabled && mode == MD_ECNT && edge_hit && cnt16_dec == match_a_reg && !wr_ctl
    |=> !enabled && ris_reg.cap_match && cnt_reg[15:0] == load_a_reg)
    else $error("edge count match did not stop and reload");
  a_ecnt_dec_one: assert property (@(posedge clk) disable iff (rst)
    enabled && mode == MD_ECNT && edge_hit && cnt16_dec != match_a_reg && !wr_load_a
    && !wr_cfg |=> cnt_reg[15:0] == $past(cnt16) - 16'h0001)
    else $error("edge did not decrement by one");
  a_etim_capture: assert property (@(posedge clk) disable iff (rst)
    enabled && mode == MD_ETIM && edge_hit |=> cap_reg == $past(cnt16) && ris_reg.cap_evt)
    else $error("edge time capture wrong");
  a_cap_hold: assert property (@(posedge clk) disable iff (rst)
    !(enabled && mode == MD_ETIM && edge_hit) |=> $stable(cap_reg))
    else $error("captured value changed without an edge");
  a_pwm_start_set: assert property (@(posedge clk) disable iff (rst)
    enabled && mode == MD_PWM && cnt16 == load_a_reg
    |=> pwm_raw_reg && pwm_out != $past(pwm_inv))
    else $error("pwm not asserted at start value");
  a_pwm_no_status: assert property (@(posedge clk) disable iff (rst)
    enabled && mode == MD_PWM && !wr_clr |=> ris_reg == $past(ris_reg))
    else $error("status changed in pwm mode");
  a_oneshot_stop: assert property (@(posedge clk) disable iff (rst)
    enabled && mode == MD_ONE && tick && cnt_zero && !wr_ctl
    |=> !enabled && ris_reg.tout) else $error("one-shot did not stop on timeout");
  a_periodic_runs: assert property (@(posedge clk) disable iff (rst)
    enabled && mode == MD_PER && tick && cnt_zero && !wr_ctl |=> enabled [*2])
    else $error("periodic timer stopped");
  a_tout_clear: assert property (@(posedge clk) disable iff (rst)
    wr_clr && writedata[0] && !sts_set.tout |=> !ris_reg.tout)
    else $error("timeout flag not cleared");
  a_load_taken: assert property (@(posedge clk) disable iff (rst)
    wr_load_a && !wr_cfg |=> cnt_reg[15:0] == $past(writedata[15:0]))
    else $error("load write not taken next cycle");
  a_rtc_div_hold: assert property (@(posedge clk) disable iff (rst)
    enabled && mode == MD_RTC && !(rise && div_reg == RTC_DIV_LAST)
    && !wr_load_a && !wr_cfg |=> $stable(cnt_reg))
    else $error("clock count moved between divided ticks");
endmodule // gptcp_timer
`default_nettype wire

// file: hw/gptcp_pkg.sv
package gptcp_pkg;
  localparam logic [6:0] OFS_CFG = 7'h00;
  localparam logic [6:0] OFS_MODE = 7'h04;
  localparam logic [6:0] OFS_CTL = 7'h0c;
  localparam logic [6:0] OFS_MASK = 7'h18;
  localparam logic [6:0] OFS_RAW = 7'h1c;
  localparam logic [6:0] OFS_MSK_STS = 7'h20;
  localparam logic [6:0] OFS_CLR = 7'h24;
  localparam logic [6:0] OFS_LOAD_A = 7'h28;
  localparam logic [6:0] OFS_LOAD_B = 7'h2c;
  localparam logic [6:0] OFS_MATCH_A = 7'h30;
  localparam logic [6:0] OFS_PRE_A = 7'h38;
  localparam logic [6:0] OFS_VAL_A = 7'h48;
  localparam logic [6:0] OFS_VAL_B = 7'h4c;
  localparam logic [2:0] CFG_32 = 3'h0;
  localparam logic [2:0] CFG_RTC = 3'h1;
  localparam logic [2:0] CFG_16 = 3'h4;
  localparam logic [1:0] MR_ONE = 2'h1;
  localparam logic [1:0] MR_PER = 2'h2;
  localparam logic [1:0] MR_CAP = 2'h3;
  // mode register fields
  localparam int MR_CMR_BIT = 2;
  localparam int MR_AMS_BIT = 3;
  // control register fields
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_EVT_LO = 2;
  localparam int CTL_CLOCK_COUNT_DURING_DEBUG_BIT = 4;
  localparam int CTL_PWML_BIT = 6;
  localparam logic [1:0] EVT_RISE = 2'h0;
  localparam logic [1:0] EVT_FALL = 2'h1;
  localparam logic [1:0] EVT_BOTH = 2'h3;
  localparam logic [15:0] LOAD_RST = 16'hffff;
  localparam logic [31:0] CNT_RST = 32'hffffffff;
  localparam logic [31:0] RTC_START = 32'h00000001;
  localparam logic [14:0] RTC_DIV_LAST = 15'h7fff;
  typedef struct packed {
    logic rtc;
    logic cap_evt;
    logic cap_match;
    logic tout;
  } gptcp_sts_t;
  typedef enum logic [2:0] {
    MD_IDLE = 3'b000,
    MD_ONE = 3'b001,
    MD_PER = 3'b010,
    MD_RTC = 3'b011,
    MD_ECNT = 3'b100,
    MD_ETIM = 3'b101,
    MD_PWM = 3'b110
  } gptcp_mode_t;
endpackage

// file: verification/gptcp_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module gptcp_pin_model (
  input wire logic clk,
  output var logic ccp_in
);
  initial ccp_in = 1'b0;
  // hold each level
  // four clocks, more than the minimum, so edges stay legal
  task toggle(input int n);
    repeat (n) begin
      @(posedge clk);
      ccp_in <= ~ccp_in;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule // gptcp_pin_model
`default_nettype wire

// file: verification/gptcp_timer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module gptcp_timer_tb;
  import gptcp_pkg::*;
  logic clk, rst, read, write, waitrequest, ccp_in, pwm_out;
  logic [6:0] address;
  logic [31:0] writedata, readdata, v, w, c;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int hi;
  gptcp_timer dut_u (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .ccp_in(ccp_in), .pwm_out(pwm_out));
  gptcp_pin_model pin_u (.clk(clk), .ccp_in(ccp_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task test_done;
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ceiling far above the several hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      test_done;
    end
  end
  // request held until waitrequest is sampled low
  task bus(input logic wr_en, input logic [6:0] a, input logic [31:0] d,
           output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr_en;
    read <= ~wr_en;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task wr(input logic [6:0] a, input logic [31:0] d);
    bus(1'b1, a, d, w);
  endtask
  task rd(input logic [6:0] a);
    bus(1'b0, a, 32'h0, v);
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task rchk(input string nm, input logic [6:0] a, input logic [31:0] exp,
            input logic [31:0] m);
    rd(a);
    chk(nm, exp & m, v & m);
  endtask
  task wait_flag(input int b);
    int n;
    n = 0;
    v = '0;
    while (v[b] !== 1'b1 && n < 400) begin
      rd(OFS_RAW);
      n++;
    end
    chk("raw_flag", 32'h1, {31'h0, v[b]});
  endtask
  task pwm_hi(input logic [31:0] exp);
    hi = 0;
    repeat (10) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      if (pwm_out === 1'b1) hi++;
    end
    chk("pwm_high", exp, 32'(hi));
  endtask
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk("cfg", OFS_CFG, 32'h0, 32'hffffffff);
    rchk("ctl", OFS_CTL, 32'h0, 32'hffffffff);
    rchk("raw", OFS_RAW, 32'h0, 32'hffffffff);
    rchk("load_b", OFS_LOAD_B, 32'hffff, 32'hffff);
    rchk("load_a", OFS_LOAD_A, 32'hffffffff, 32'hffffffff);
    wr(7'h7c, 32'h5a5a5a5a);
    rchk("unmapped", 7'h7c, 32'h0, 32'hffffffff);
    // edge count: four of six edges counted, then stopped
    wr(OFS_CFG, 32'h4);
    wr(OFS_MODE, 32'h3);
    wr(OFS_LOAD_A, 32'h000a);
    wr(OFS_MATCH_A, 32'h0006);
    wr(OFS_MASK, 32'h2);
    wr(OFS_CTL, 32'hd);
    pin_u.toggle(6);
    repeat (4) @(posedge clk);
    rchk("ecnt_raw", OFS_RAW, 32'h2, 32'hf);
    rchk("ecnt_msk", OFS_MSK_STS, 32'h2, 32'hf);
    rchk("ecnt_ctl", OFS_CTL, 32'hc, 32'hff);
    rchk("ecnt_val", OFS_VAL_A, 32'h000a, 32'hffff);
    wr(OFS_CLR, 32'h2);
    rchk("ecnt_clr", OFS_RAW, 32'h0, 32'hf);
    // edge time on rising edges only
    wr(OFS_CTL, 32'h0);
    wr(OFS_MODE, 32'h7);
    wr(OFS_LOAD_A, 32'h0040);
    wr(OFS_CTL, 32'h1);
    pin_u.toggle(1);
    repeat (4) @(posedge clk);
    rchk("etim_raw", OFS_RAW, 32'h4, 32'hf);
    c = v;
    rd(OFS_VAL_A);
    c = v;
    chk("etim_range", 32'h1, {31'h0, c[15:0] <= 16'h0040});
    repeat (100) @(posedge clk);
    rchk("etim_hold", OFS_VAL_A, c, 32'hffff);
    wr(OFS_CLR, 32'h4);
    pin_u.toggle(1);
    repeat (4) @(posedge clk);
    rchk("etim_fall", OFS_RAW, 32'h0, 32'hf);
    rchk("etim_keep", OFS_VAL_A, c, 32'hffff);
    // pwm: period ten, high six, no status
    wr(OFS_CTL, 32'h0);
    wr(OFS_CLR, 32'hf);
    wr(OFS_MODE, 32'ha);
    wr(OFS_LOAD_A, 32'h0009);
    wr(OFS_MATCH_A, 32'h0003);
    wr(OFS_CTL, 32'h1);
    pwm_hi(32'd24);
    rchk("pwm_raw", OFS_RAW, 32'h0, 32'hf);
    wr(OFS_CTL, 32'h0);
    wr(OFS_CTL, 32'h41);
    pwm_hi(32'd16);
    // split one-shot, prescale three: one count per four clocks
    wr(OFS_CTL, 32'h0);
    wr(OFS_MODE, 32'h1);
    wr(OFS_PRE_A, 32'h3);
    wr(OFS_LOAD_A, 32'h0004);
    wr(OFS_CTL, 32'h1);
    repeat (6) @(posedge clk);
    rchk("pre_val", OFS_VAL_A, 32'h2, 32'hffff);
    wait_flag(0);
    rchk("pre_ctl", OFS_CTL, 32'h0, 32'h1);
    wr(OFS_CLR, 32'h1);
    // 32-bit one-shot, then periodic
    wr(OFS_CTL, 32'h0);
    wr(OFS_CFG, 32'h0);
    wr(OFS_MODE, 32'h1);
    wr(OFS_LOAD_A, 32'h00000020);
    rchk("load_b_split", OFS_LOAD_B, 32'h0, 32'hffff);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CTL, 32'h1);
    wait_flag(0);
    rchk("one_ctl", OFS_CTL, 32'h0, 32'h1);
    repeat (60) @(posedge clk);
    rchk("one_val", OFS_VAL_A, 32'h00000020, 32'hffffffff);
    rchk("one_msk", OFS_MSK_STS, 32'h1, 32'hf);
    wr(OFS_CLR, 32'h1);
    rchk("one_clr", OFS_RAW, 32'h0, 32'hf);
    rchk("one_mclr", OFS_MSK_STS, 32'h0, 32'hf);
    wr(OFS_MODE, 32'h2);
    wr(OFS_CTL, 32'h1);
    wait_flag(0);
    wr(OFS_CLR, 32'h1);
    wait_flag(0);
    rchk("per_ctl", OFS_CTL, 32'h1, 32'h1);
    wr(OFS_LOAD_A, 32'h00000100);
    rd(OFS_VAL_A);
    chk("per_newload", 32'h1, {31'h0, v > 32'h20 && v <= 32'h100});
    wr(OFS_CTL, 32'h0);
    wr(OFS_CFG, 32'h1);
    rchk("rtc_start", OFS_VAL_A, 32'h00000001, 32'hffffffff);
    wr(OFS_MATCH_A, 32'h0005);
    wr(OFS_CTL, 32'h11);
    pin_u.toggle(4);
    rchk("rtc_div", OFS_VAL_A, 32'h00000001, 32'hffffffff);
    test_done;
  end
endmodule // gptcp_timer_tb
`default_nettype wire
